// >>> hw/cci_cfg.svh
// Constants for the combined custom instruction unit.
// Assumes inclusion by bare name from cci design files.
`ifndef CCI_CFG_SVH
`define CCI_CFG_SVH
`define CCI_DATA_W       32
`define CCI_SEL_W        2
`define CCI_NUM_FUNCS    4
`define CCI_FIX_LAT      3
`define CCI_MUX_STAGES   1
`define CCI_SEL_ADD      2'h0
`define CCI_SEL_XOR      2'h1
`define CCI_SEL_MUL      2'h2
`define CCI_SEL_DIV      2'h3
`define CCI_RESULT_RST   32'h0000_0000
`endif

// >>> hw/cci_pkg.sv
// Types for the combined custom instruction unit.
// Assumes cci_cfg.svh is on the include path.
`include "cci_cfg.svh"
package cci_pkg;
   typedef enum logic [1:0] {
      CCI_IDLE = 2'b00,
      CCI_BUSY = 2'b01
   } cci_div_state_t;
   typedef logic [`CCI_DATA_W-1:0] cci_word_t;
endpackage : cci_pkg

// >>> hw/cci_delay_chain.sv
// Shift chain that delays a start pulse by a fixed count of cycles.
// Assumes one clock, async active-high reset, and a clock enable.
`timescale 1ns/1ps
module cci_delay_chain #(
   parameter int DEPTH = 3
) (
   input  wire logic mclk_in,
   input  wire logic rst_in,
   input  wire logic ce_in,
   input  wire logic start_in,
   output logic      done_out
);
   logic [DEPTH-1:0] chain_q;
   if (DEPTH < 1) begin : g_bad_depth
      $error("cci_delay_chain: DEPTH must be at least 1");
   end
   // Bitwise shift, so a one-stage chain needs no special case
   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         chain_q <= '0;
      end else if (ce_in) begin
         chain_q[0] <= start_in; // RULE8
         for (int i = 1; i < DEPTH; i++) begin
            chain_q[i] <= chain_q[i-1];
         end
      end
   end
   assign done_out = chain_q[DEPTH-1];
endmodule : cci_delay_chain

// >>> hw/cci_unit.sv
// Combined custom instruction unit: four functions behind one slave port.
// Assumes the processor holds operands and selector while it waits for done.
// How it works
// RULE1: Two operands go in and one result comes out, with clock, reset, selector and status.
// RULE2: The processor blocks and issues nothing new until done is seen.
// RULE3: The processor places this result on its own 32-bit result multiplexer.
// RULE4: The selector is decoded to pick a function and an internal mux picks its output.
// RULE5: The internal mux may be registered in extra stages, each adding a cycle of latency.
// RULE6: All functions present the same variable-latency handshake at the shared port.
// RULE7: Each function is either fixed latency or variable latency with its own done.
// RULE8: Fixed functions get done from a delayed start and all done bits are ORed.
// RULE9: Operands arrive and the result leaves over the same slave port.
// RULE10: Done pulses one cycle per accepted start with the result valid in that cycle.
`timescale 1ns/1ps
`include "cci_cfg.svh"
module cci_unit #(
   parameter int DATA_W     = `CCI_DATA_W,
   parameter int FIX_LAT    = `CCI_FIX_LAT,
   parameter int MUX_STAGES = `CCI_MUX_STAGES
) (
   input  wire logic                  mclk_in,
   input  wire logic                  rst_in,
   input  wire logic                  ce_in,
   input  wire logic                  start_in,
   input  wire logic [`CCI_SEL_W-1:0] sel_in,
   input  wire logic [DATA_W-1:0]     dataa_in,
   input  wire logic [DATA_W-1:0]     datab_in,
   output logic                       done_out,
   output logic [DATA_W-1:0]          result_out
);
   // Elaboration checks: pipes and counters need at least one stage
   if (DATA_W < 2) begin : g_bad_data_w
      $error("cci_unit: DATA_W too small");
   end
   if (FIX_LAT < 1) begin : g_bad_fix_lat
      $error("cci_unit: FIX_LAT must be at least 1");
   end
   if (MUX_STAGES < 0 || MUX_STAGES > 4) begin : g_bad_mux_stages
      $error("cci_unit: MUX_STAGES out of range");
   end

   function automatic logic sel_is(input logic [`CCI_SEL_W-1:0] s,
                                   input logic [`CCI_SEL_W-1:0] code);
      sel_is = (s == code);
   endfunction : sel_is

   // Start is qualified per function by the decoded selector
   logic go_add;
   logic go_xor;
   logic go_mul;
   logic go_div;
   assign go_add = start_in && sel_is(sel_in, `CCI_SEL_ADD); // RULE4
   assign go_xor = start_in && sel_is(sel_in, `CCI_SEL_XOR); // RULE4
   assign go_mul = start_in && sel_is(sel_in, `CCI_SEL_MUL); // RULE4
   assign go_div = start_in && sel_is(sel_in, `CCI_SEL_DIV); // RULE4

   // Fixed-latency functions: pipelined datapath plus delayed start
   logic [DATA_W-1:0] add_pipe_q [FIX_LAT];
   logic [DATA_W-1:0] xor_pipe_q [FIX_LAT];
   logic [DATA_W-1:0] mul_pipe_q [FIX_LAT];
   // Carry dropped on purpose, result is one word
   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         for (int i = 0; i < FIX_LAT; i++) begin
            add_pipe_q[i] <= '0;
         end
      end else if (ce_in) begin
         add_pipe_q[0] <= DATA_W'(dataa_in + datab_in); // RULE1
         for (int i = 1; i < FIX_LAT; i++) begin
            add_pipe_q[i] <= add_pipe_q[i-1];
         end
      end
   end

   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         for (int i = 0; i < FIX_LAT; i++) begin
            xor_pipe_q[i] <= '0;
         end
      end else if (ce_in) begin
         xor_pipe_q[0] <= dataa_in ^ datab_in; // RULE1
         for (int i = 1; i < FIX_LAT; i++) begin
            xor_pipe_q[i] <= xor_pipe_q[i-1];
         end
      end
   end

   // Low word only, upper product bits are not returned
   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         for (int i = 0; i < FIX_LAT; i++) begin
            mul_pipe_q[i] <= '0;
         end
      end else if (ce_in) begin
         mul_pipe_q[0] <= DATA_W'(dataa_in * datab_in); // RULE1
         for (int i = 1; i < FIX_LAT; i++) begin
            mul_pipe_q[i] <= mul_pipe_q[i-1];
         end
      end
   end

   logic done_add;
   logic done_xor;
   logic done_mul;
   cci_delay_chain #(.DEPTH(FIX_LAT)) u_dly_add ( // RULE8
      .mclk_in (mclk_in),
      .rst_in  (rst_in),
      .ce_in   (ce_in),
      .start_in(go_add),
      .done_out(done_add)
   );
   cci_delay_chain #(.DEPTH(FIX_LAT)) u_dly_xor ( // RULE8
      .mclk_in (mclk_in),
      .rst_in  (rst_in),
      .ce_in   (ce_in),
      .start_in(go_xor),
      .done_out(done_xor)
   );
   cci_delay_chain #(.DEPTH(FIX_LAT)) u_dly_mul ( // RULE8
      .mclk_in (mclk_in),
      .rst_in  (rst_in),
      .ce_in   (ce_in),
      .start_in(go_mul),
      .done_out(done_mul)
   );

   // Variable-latency function: restoring unsigned divide, one bit a cycle
   localparam int CW = $clog2(DATA_W + 1);
   cci_pkg::cci_div_state_t div_state_q;
   logic [DATA_W-1:0] div_quo_q;
   logic [DATA_W-1:0] div_rem_q;
   logic [DATA_W-1:0] div_den_q;
   logic [CW-1:0]     div_cnt_q;
   logic              div_done_q;
   logic [DATA_W:0]   div_trial;
   assign div_trial = {div_rem_q, div_quo_q[DATA_W-1]} - {1'b0, div_den_q};
   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         div_state_q <= cci_pkg::CCI_IDLE;
         div_quo_q   <= '0;
         div_rem_q   <= '0;
         div_den_q   <= '0;
         div_cnt_q   <= '0;
      end else if (ce_in) begin
         unique case (div_state_q)
            cci_pkg::CCI_IDLE: begin
               if (go_div) begin // RULE7
                  div_quo_q   <= dataa_in;
                  div_rem_q   <= '0;
                  div_den_q   <= datab_in;
                  div_cnt_q   <= CW'(DATA_W);
                  div_state_q <= cci_pkg::CCI_BUSY;
               end
            end
            cci_pkg::CCI_BUSY: begin
               // Divide by zero yields all ones, no trap
               if (!div_trial[DATA_W]) begin
                  div_rem_q <= div_trial[DATA_W-1:0];
                  div_quo_q <= {div_quo_q[DATA_W-2:0], 1'b1};
               end else begin
                  div_rem_q <= {div_rem_q[DATA_W-2:0], div_quo_q[DATA_W-1]};
                  div_quo_q <= {div_quo_q[DATA_W-2:0], 1'b0};
               end
               div_cnt_q <= div_cnt_q - CW'(1);
               if (div_cnt_q == CW'(1)) begin
                  div_state_q <= cci_pkg::CCI_IDLE;
               end
            end
            default: div_state_q <= cci_pkg::CCI_IDLE;
         endcase
      end
   end

   // Divider done, one enabled cycle on the last quotient bit
   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         div_done_q <= 1'b0;
      end else if (ce_in) begin
         div_done_q <= (div_state_q == cci_pkg::CCI_BUSY) && (div_cnt_q == CW'(1)); // RULE7
      end
   end

   // Output mux keyed by which done fired, so no selector hold is needed here
   logic              any_done;
   logic [DATA_W-1:0] mux_d;
   assign any_done = done_add | done_xor | done_mul | div_done_q; // RULE8
   always_comb begin
      mux_d = '0;
      if (done_add) mux_d = add_pipe_q[FIX_LAT-1]; // RULE4
      if (done_xor) mux_d = xor_pipe_q[FIX_LAT-1];
      if (done_mul) mux_d = mul_pipe_q[FIX_LAT-1];
      if (div_done_q) mux_d = div_quo_q;
   end

   // Mux pipeline keeps the done-keyed output mux off the processor critical path
   logic [DATA_W-1:0] stg_data_q [MUX_STAGES+1];
   logic              stg_done_q [MUX_STAGES+1];
   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         for (int i = 0; i <= MUX_STAGES; i++) begin
            stg_data_q[i] <= DATA_W'(`CCI_RESULT_RST);
         end
      end else if (ce_in) begin
         stg_data_q[0] <= mux_d; // RULE5
         for (int i = 1; i <= MUX_STAGES; i++) begin
            stg_data_q[i] <= stg_data_q[i-1]; // RULE5
         end
      end
   end

   // Done runs beside the data stages so the pair never splits
   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         for (int i = 0; i <= MUX_STAGES; i++) begin
            stg_done_q[i] <= 1'b0;
         end
      end else if (ce_in) begin
         stg_done_q[0] <= any_done; // RULE6
         for (int i = 1; i <= MUX_STAGES; i++) begin
            stg_done_q[i] <= stg_done_q[i-1];
         end
      end
   end

   // Done and result share a stage, so both appear in one cycle
   assign done_out   = stg_done_q[MUX_STAGES]; // RULE10
   assign result_out = stg_data_q[MUX_STAGES]; // RULE9
endmodule : cci_unit

// >>> bench/cci_unit_assertions.sv
// Checker bound to cci_unit.
// Sees the unit's ports only.
`timescale 1ns/1ps
module cci_unit_assertions #(
   parameter int DATA_W     = 32,
   parameter int FIX_LAT    = 3,
   parameter int MUX_STAGES = 1
) (
   input logic              mclk_in,
   input logic              rst_in,
   input logic              ce_in,
   input logic              start_in,
   input logic [1:0]        sel_in,
   input logic [DATA_W-1:0] dataa_in,
   input logic [DATA_W-1:0] datab_in,
   input logic              done_out,
   input logic [DATA_W-1:0] result_out
);
   logic [DATA_W-1:0] exp_q;
   logic [7:0]        cnt_q;
   logic              busy_q;
   default clocking @(posedge mclk_in); endclocking
   default disable iff (rst_in);
   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         {busy_q, cnt_q, exp_q} <= '0;
      end else if (ce_in) begin
         busy_q <= start_in || (busy_q && !done_out);
         // Counts down, zero in the cycle done is due
         cnt_q <= start_in ? 8'(sel_in == 2'h3 ? DATA_W + MUX_STAGES + 1 : FIX_LAT + MUX_STAGES)
            : cnt_q - 8'h01;
         if (start_in) begin
            case (sel_in)
               2'h0: exp_q <= DATA_W'(dataa_in + datab_in);
               2'h1: exp_q <= dataa_in ^ datab_in;
               2'h2: exp_q <= DATA_W'(dataa_in * datab_in);
               default: exp_q <= (datab_in == '0) ? '1 : dataa_in / datab_in;
            endcase
         end
      end
   end
   a_done_pulse: assert property (done_out && ce_in |=> !done_out)
      else $error("done held too long");
   a_done_cause: assert property (done_out |-> busy_q)
      else $error("done without start");
   a_done_time: assert property (done_out |-> cnt_q == 8'h00)
      else $error("done at wrong cycle");
   a_result_sel: assert property (done_out |-> result_out == exp_q)
      else $error("wrong result");
   a_fixed_lat: assert property (start_in && ce_in && sel_in != 2'h3
      ##1 ce_in[*4] |=> done_out) else $error("fixed function late");
   a_mux_stage: assert property (start_in && ce_in |=> !done_out[*4])
      else $error("done too early");
   a_reset_idle: assert property ($fell(rst_in) |-> !done_out && result_out == '0)
      else $error("busy after reset");
   a_ce_hold: assert property (!ce_in |=> $stable(done_out) && $stable(result_out))
      else $error("moved while disabled");
   c_div: cover property (start_in && ce_in && sel_in == 2'h3);
   c_stall: cover property (busy_q && !ce_in);
   c_back: cover property (done_out ##1 start_in);
endmodule : cci_unit_assertions
bind cci_unit cci_unit_assertions #(.DATA_W(DATA_W), .FIX_LAT(FIX_LAT),
   .MUX_STAGES(MUX_STAGES)) i_cci_unit_assertions (.mclk_in(mclk_in), .rst_in(rst_in),
   .ce_in(ce_in), .start_in(start_in), .sel_in(sel_in), .dataa_in(dataa_in),
   .datab_in(datab_in), .done_out(done_out), .result_out(result_out));

// >>> bench/cci_cpu_model.sv
// Processor side: one blocking instruction at a time.
// Clock enable comes from the testbench.
`timescale 1ns/1ps
module cci_cpu_model (
   input  logic        mclk_in,
   input  logic        ce_in,
   input  logic        done_in,
   input  logic [31:0] result_in,
   output logic        start_out,
   output logic [1:0]  sel_out,
   output logic [31:0] dataa_out,
   output logic [31:0] datab_out
);
   initial {start_out, sel_out, dataa_out, datab_out} = '0;
   // Lat stays -1 on a hang
   task automatic issue(input logic [1:0] f, input logic [31:0] a, b,
                        output logic [31:0] res, output int lat);
      lat = -1;
      @(negedge mclk_in);
      {start_out, sel_out, dataa_out, datab_out} = {1'b1, f, a, b};
      @(posedge mclk_in);
      for (int k = 0; k < 64 && !ce_in; k++) @(posedge mclk_in);
      start_out <= 1'b0;
      for (int i = 1; i < 200 && lat < 0; i++) begin
         @(posedge mclk_in);
         if (done_in) begin
            res = result_in;
            lat = i;
            // Released operands must not look valid
            {dataa_out, datab_out} <= {~a, ~b};
         end
      end
   endtask : issue
endmodule : cci_cpu_model

// >>> bench/testbench.sv
// Random instructions through the processor model.
// Assumes cci_cfg.svh on the include path.
`timescale 1ns/1ps
`include "cci_cfg.svh"
module testbench;
   logic        mclk_in, rst_in, ce, stall, st, dn;
   logic [1:0]  s;
   logic [31:0] a, b, r, res;
   int          lat, seed, bad_count, tests_run;
   cci_unit i_cci_unit (.mclk_in(mclk_in), .rst_in(rst_in), .ce_in(ce), .start_in(st),
      .sel_in(s), .dataa_in(a), .datab_in(b), .done_out(dn), .result_out(r));
   cci_cpu_model i_cci_cpu_model (.mclk_in(mclk_in), .ce_in(ce), .done_in(dn),
      .result_in(r), .start_out(st), .sel_out(s), .dataa_out(a), .datab_out(b));
   initial begin
      mclk_in = 1'b0;
      forever #2.5 mclk_in = ~mclk_in;
   end
   // Stalls only late, so latency is timed at full rate
   always @(negedge mclk_in) ce <= stall ? 1'($random(seed)) : 1'b1;
   function automatic logic [31:0] lat_fn(input logic [1:0] f);
      return (f == `CCI_SEL_DIV) ? `CCI_DATA_W + `CCI_MUX_STAGES + 2
                                 : `CCI_FIX_LAT + `CCI_MUX_STAGES + 1;
   endfunction : lat_fn
   function automatic logic [31:0] exp_fn(input logic [1:0] f, input logic [31:0] x, y);
      case (f)
         `CCI_SEL_ADD: return 32'(x + y);
         `CCI_SEL_XOR: return x ^ y;
         `CCI_SEL_MUL: return 32'(x * y);
         default: return (y == 32'h0) ? 32'hffff_ffff : x / y;
      endcase
   endfunction : exp_fn
   task automatic check(input logic [31:0] seen, exp);
      tests_run++;
      if (seen !== exp) begin
         bad_count++;
         $display("BAD %0t seen %h want %h", $time, seen, exp);
      end
   endtask : check
   task automatic stop_test();
      $display("checks %0d bad %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : stop_test
   task automatic run(input logic [1:0] f, input logic [31:0] x, y);
      i_cci_cpu_model.issue(f, x, y, res, lat);
      if (lat < 0) begin
         bad_count++;
         $display("BAD %0t no done", $time);
         stop_test();
      end else begin
         if (!stall) check(32'(lat), lat_fn(f));
         check(res, exp_fn(f, x, y));
         if (f == `CCI_SEL_DIV && y == 0) check(res, 32'hffff_ffff);
      end
   endtask : run
   initial begin
      seed = 32'hb7ce;
      bad_count = 0;
      tests_run = 0;
      stall = 1'b0;
      rst_in = 1'b1;
      repeat (8) @(posedge mclk_in);
      @(negedge mclk_in) rst_in = 1'b0;
      check(r, `CCI_RESULT_RST);
      check(32'(dn), 32'h0);
      for (int f = 0; f < 4; f++) begin
         run(2'(f), 32'hffff_ffff, 32'h1);
         run(2'(f), 32'h8000_0001, 32'h0);
      end
      repeat (40) run(2'($random(seed)), $random(seed), $random(seed));
      stall = 1'b1;
      repeat (20) run(2'($random(seed)), $random(seed), $random(seed));
      stop_test();
   end
endmodule : testbench
